// ---- rtl/rlpc_top.sv ----
//
// Purpose: Executes relative work polyline, pointer set/shift and
//          local offset commands from a display-list word stream.
// Assumes: Words arrive with valid/ready; pixel writes use valid/ready.
// Notes:   Unknown codes are skipped as header-only words.
//
// Operation
// - Code 01011 is relative polyline with 1..65535 vertices of dx/dy pairs.
// - Segments chain from the pointer; each vertex adds the next delta pair.
// - Plotted pixels get value 0 or 1 from draw_value_select.
// - After the polyline the last vertex becomes the pointer.
// - Lines rasterize with eight-neighbour steps, diagonal steps allowed.
// - Code 10000 loads pointer with absolute coordinates plus local offset.
// - Pointer set words are absolute values, not displacements.
// - Pointer is used only by relative drawing commands.
// - Absolute drawing may corrupt the pointer; host re-sets it afterward.
// - Code 10001 adds relative values to the pointer.
// - Code 10010 loads the local offset registers.
// - The local offset is added to later specified coordinates.
//
`timescale 1ns/1ps

module rlpc_top #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic          CLK_IN,
	input  wire logic          SYS_RST_IN,
	// Display-list word stream
	input  wire logic          WORD_VALID_IN,
	input  wire logic [W-1:0]  WORD_DATA_IN,
	output logic               WORD_READY_OUT,
	// Work-plane pixel writes
	output logic               PIX_VALID_OUT,
	input  wire logic          PIX_READY_IN,
	output logic [W-1:0]       PIX_X_OUT,
	output logic [W-1:0]       PIX_Y_OUT,
	output logic               PIX_VALUE_OUT,
	// State
	output logic [W-1:0]       POINTER_X_OUT,
	output logic [W-1:0]       POINTER_Y_OUT,
	output logic [W-1:0]       OFFSET_X_OUT,
	output logic [W-1:0]       OFFSET_Y_OUT,
	output logic               BUSY_OUT
);

	// ****************************************************************
	// State
	// ****************************************************************
	rlpc_pkg::rlpc_state_t state_reg, state_next;
	logic [4:0]   code_reg, code_next;
	logic         value_reg, value_next;
	logic [W-1:0] p0_reg, p0_next;
	logic [W-1:0] cnt_reg, cnt_next;
	logic [W-1:0] dx_reg, dx_next;
	logic [W-1:0] px_reg, px_next;
	logic [W-1:0] py_reg, py_next;
	logic [W-1:0] ox_reg, ox_next;
	logic [W-1:0] oy_reg, oy_next;
	logic [W-1:0] cx_reg, cx_next;
	logic [W-1:0] cy_reg, cy_next;
	logic [W-1:0] ex_reg, ex_next;
	logic [W-1:0] ey_reg, ey_next;
	logic [W-1:0] adx_reg, adx_next;
	logic [W-1:0] ady_reg, ady_next;
	logic         sx_reg, sx_next;
	logic         sy_reg, sy_next;
	logic [W:0]   err_reg, err_next;
	logic         pv_reg, pv_next;
	logic [W-1:0] ox_pix_reg, ox_pix_next;
	logic [W-1:0] oy_pix_reg, oy_pix_next;

	logic         take;
	logic [4:0]   hdr_code;
	logic [W+1:0] e2;

	// Absolute value of a two's-complement word.
	function automatic logic [W-1:0] magn(input logic [W-1:0] v);
		magn = v[W-1] ? (~v + rlpc_pkg::ONE16[W-1:0]) : v;
	endfunction : magn

	assign hdr_code       = WORD_DATA_IN[rlpc_pkg::CODE_HI:rlpc_pkg::CODE_LO];
	assign WORD_READY_OUT = (state_reg != rlpc_pkg::RLPC_LINE);
	assign take           = WORD_VALID_IN && WORD_READY_OUT;
	assign e2             = {err_reg, 1'b0};

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		state_next  = state_reg;
		code_next   = code_reg;
		value_next  = value_reg;
		p0_next     = p0_reg;
		cnt_next    = cnt_reg;
		dx_next     = dx_reg;
		px_next     = px_reg;
		py_next     = py_reg;
		ox_next     = ox_reg;
		oy_next     = oy_reg;
		cx_next     = cx_reg;
		cy_next     = cy_reg;
		ex_next     = ex_reg;
		ey_next     = ey_reg;
		adx_next    = adx_reg;
		ady_next    = ady_reg;
		sx_next     = sx_reg;
		sy_next     = sy_reg;
		err_next    = err_reg;
		pv_next     = pv_reg;
		ox_pix_next = ox_pix_reg;
		oy_pix_next = oy_pix_reg;
		unique case (state_reg)
			rlpc_pkg::RLPC_HDR: begin
				if (take) begin
					code_next  = hdr_code;
					value_next = WORD_DATA_IN[rlpc_pkg::VALUE_BIT];
					unique case (hdr_code)
						rlpc_pkg::CMD_REL_POLY:
							state_next = rlpc_pkg::RLPC_CNT;
						rlpc_pkg::CMD_MOVE,
						rlpc_pkg::CMD_PTR_SHIFT,
						rlpc_pkg::CMD_OFS_SET:
							state_next = rlpc_pkg::RLPC_P0;
						// Other codes, absolute drawing among them, keep the pointer.
						default:
							state_next = rlpc_pkg::RLPC_HDR;
					endcase
				end
			end
			rlpc_pkg::RLPC_P0: begin
				if (take) begin
					p0_next    = WORD_DATA_IN;
					state_next = rlpc_pkg::RLPC_P1;
				end
			end
			rlpc_pkg::RLPC_P1: begin
				if (take) begin
					state_next = rlpc_pkg::RLPC_HDR;
					if (code_reg == rlpc_pkg::CMD_MOVE) begin
						px_next = p0_reg + ox_reg;
						py_next = WORD_DATA_IN + oy_reg;
					end else if (code_reg == rlpc_pkg::CMD_PTR_SHIFT) begin
						px_next = px_reg + p0_reg;
						py_next = py_reg + WORD_DATA_IN;
					end else begin
						ox_next = p0_reg;
						oy_next = WORD_DATA_IN;
					end
				end
			end
			rlpc_pkg::RLPC_CNT: begin
				if (take) begin
					cnt_next   = WORD_DATA_IN;
					cx_next    = px_reg;
					cy_next    = py_reg;
					state_next = (WORD_DATA_IN == rlpc_pkg::ZERO16[W-1:0]) ?
						rlpc_pkg::RLPC_HDR : rlpc_pkg::RLPC_DX;
				end
			end
			rlpc_pkg::RLPC_DX: begin
				if (take) begin
					dx_next    = WORD_DATA_IN;
					state_next = rlpc_pkg::RLPC_DY;
				end
			end
			rlpc_pkg::RLPC_DY: begin
				if (take) begin
					ex_next    = cx_reg + dx_reg;
					ey_next    = cy_reg + WORD_DATA_IN;
					adx_next   = magn(dx_reg);
					ady_next   = magn(WORD_DATA_IN);
					sx_next    = dx_reg[W-1];
					sy_next    = WORD_DATA_IN[W-1];
					err_next   = {1'b0, magn(dx_reg)} - {1'b0, magn(WORD_DATA_IN)};
					pv_next    = 1'b1;
					ox_pix_next = cx_reg;
					oy_pix_next = cy_reg;
					state_next = rlpc_pkg::RLPC_LINE;
				end
			end
			rlpc_pkg::RLPC_LINE: begin
				if (pv_reg && PIX_READY_IN) begin
					if (cx_reg == ex_reg && cy_reg == ey_reg) begin
						pv_next  = 1'b0;
						cnt_next = cnt_reg - rlpc_pkg::ONE16[W-1:0];
						if (cnt_reg == rlpc_pkg::ONE16[W-1:0]) begin
							px_next    = ex_reg;
							py_next    = ey_reg;
							state_next = rlpc_pkg::RLPC_HDR;
						end else begin
							state_next = rlpc_pkg::RLPC_DX;
						end
					end else begin
						// Both axes may step in one move.
						err_next = err_reg;
						if ($signed(e2) > -$signed({2'b00, ady_reg})) begin
							err_next = err_next - {1'b0, ady_reg};
							cx_next  = sx_reg ? cx_reg - rlpc_pkg::ONE16[W-1:0]
							                  : cx_reg + rlpc_pkg::ONE16[W-1:0];
						end
						if ($signed(e2) < $signed({2'b00, adx_reg})) begin
							err_next = err_next + {1'b0, adx_reg};
							cy_next  = sy_reg ? cy_reg - rlpc_pkg::ONE16[W-1:0]
							                  : cy_reg + rlpc_pkg::ONE16[W-1:0];
						end
						ox_pix_next = cx_next;
						oy_pix_next = cy_next;
					end
				end
			end
			default: state_next = rlpc_pkg::RLPC_HDR;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			state_reg  <= rlpc_pkg::RLPC_HDR;
			code_reg   <= 5'h00;
			value_reg  <= 1'b0;
			p0_reg     <= rlpc_pkg::ZERO16[W-1:0];
			cnt_reg    <= rlpc_pkg::ZERO16[W-1:0];
			dx_reg     <= rlpc_pkg::ZERO16[W-1:0];
			px_reg     <= rlpc_pkg::ZERO16[W-1:0];
			py_reg     <= rlpc_pkg::ZERO16[W-1:0];
			ox_reg     <= rlpc_pkg::ZERO16[W-1:0];
			oy_reg     <= rlpc_pkg::ZERO16[W-1:0];
			cx_reg     <= rlpc_pkg::ZERO16[W-1:0];
			cy_reg     <= rlpc_pkg::ZERO16[W-1:0];
			ex_reg     <= rlpc_pkg::ZERO16[W-1:0];
			ey_reg     <= rlpc_pkg::ZERO16[W-1:0];
			adx_reg    <= rlpc_pkg::ZERO16[W-1:0];
			ady_reg    <= rlpc_pkg::ZERO16[W-1:0];
			sx_reg     <= 1'b0;
			sy_reg     <= 1'b0;
			err_reg    <= '0;
			pv_reg     <= 1'b0;
			ox_pix_reg <= rlpc_pkg::ZERO16[W-1:0];
			oy_pix_reg <= rlpc_pkg::ZERO16[W-1:0];
		end else begin
			state_reg  <= state_next;
			code_reg   <= code_next;
			value_reg  <= value_next;
			p0_reg     <= p0_next;
			cnt_reg    <= cnt_next;
			dx_reg     <= dx_next;
			px_reg     <= px_next;
			py_reg     <= py_next;
			ox_reg     <= ox_next;
			oy_reg     <= oy_next;
			cx_reg     <= cx_next;
			cy_reg     <= cy_next;
			ex_reg     <= ex_next;
			ey_reg     <= ey_next;
			adx_reg    <= adx_next;
			ady_reg    <= ady_next;
			sx_reg     <= sx_next;
			sy_reg     <= sy_next;
			err_reg    <= err_next;
			pv_reg     <= pv_next;
			ox_pix_reg <= ox_pix_next;
			oy_pix_reg <= oy_pix_next;
		end
	end

	assign PIX_VALID_OUT = pv_reg;
	assign PIX_X_OUT     = ox_pix_reg;
	assign PIX_Y_OUT     = oy_pix_reg;
	assign PIX_VALUE_OUT = value_reg;
	assign POINTER_X_OUT = px_reg;
	assign POINTER_Y_OUT = py_reg;
	assign OFFSET_X_OUT  = ox_reg;
	assign OFFSET_Y_OUT  = oy_reg;
	assign BUSY_OUT      = (state_reg != rlpc_pkg::RLPC_HDR);

endmodule : rlpc_top

// ---- rtl/rlpc_pkg.sv ----
//
// Purpose: Constants for the relative line and pointer command block.
// Assumes: 16-bit display-list words, code in bits 15:11.
// Notes:   Draw-mode field occupies bits 10:0.
//
package rlpc_pkg;

	// ****************************************************************
	// Word layout
	// ****************************************************************
	localparam int WORD_W    = 16;
	localparam int CODE_HI   = 15;
	localparam int CODE_LO   = 11;
	localparam int VALUE_BIT = 4;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [4:0] CMD_REL_POLY  = 5'h0B;
	localparam logic [4:0] CMD_MOVE      = 5'h10;
	localparam logic [4:0] CMD_PTR_SHIFT = 5'h11;
	localparam logic [4:0] CMD_OFS_SET   = 5'h12;

	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] ONE16  = 16'h0001;

	typedef enum logic [3:0] {
		RLPC_HDR,
		RLPC_P0,
		RLPC_P1,
		RLPC_CNT,
		RLPC_DX,
		RLPC_DY,
		RLPC_LINE,
		RLPC_SKIP
	} rlpc_state_t;

endpackage : rlpc_pkg

// ---- testbench/rlpc_top_checker.sv ----
// Purpose: Port assertions for the relative line and pointer block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the top module from the bench top file.
`timescale 1ns/1ps
module rlpc_top_checker #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic         CLK_IN,
	input wire logic         SYS_RST_IN,
	// Word stream
	input wire logic         WORD_VALID_IN,
	input wire logic [W-1:0] WORD_DATA_IN,
	input wire logic         WORD_READY_OUT,
	// Pixel writes
	input wire logic         PIX_VALID_OUT,
	input wire logic         PIX_READY_IN,
	input wire logic [W-1:0] PIX_X_OUT,
	input wire logic [W-1:0] PIX_Y_OUT,
	input wire logic         PIX_VALUE_OUT,
	// State
	input wire logic [W-1:0] POINTER_X_OUT,
	input wire logic [W-1:0] POINTER_Y_OUT,
	input wire logic [W-1:0] OFFSET_X_OUT,
	input wire logic [W-1:0] OFFSET_Y_OUT,
	input wire logic         BUSY_OUT
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	sequence pix_taken;
		PIX_VALID_OUT && PIX_READY_IN;
	endsequence
	reset_clear_a: assert property (disable iff (1'b0) SYS_RST_IN |=>
		!PIX_VALID_OUT && WORD_READY_OUT && !BUSY_OUT &&
		POINTER_X_OUT == '0 && OFFSET_Y_OUT == '0)
		else $error("state not cleared by reset");
	pix_hold_a: assert property (PIX_VALID_OUT && !PIX_READY_IN |=>
		PIX_VALID_OUT && $stable(PIX_X_OUT) && $stable(PIX_Y_OUT))
		else $error("pixel dropped or changed while stalled");
	ready_block_a: assert property (PIX_VALID_OUT |-> !WORD_READY_OUT)
		else $error("word accepted while drawing");
	idle_ready_a: assert property (!BUSY_OUT |-> WORD_READY_OUT)
		else $error("idle but not ready for a header");
	offset_cause_a: assert property (!$stable(OFFSET_X_OUT) ||
		!$stable(OFFSET_Y_OUT) |-> $past(SYS_RST_IN) ||
		$past(WORD_VALID_IN && WORD_READY_OUT))
		else $error("offset changed without a word");
	pointer_cause_a: assert property (!$stable(POINTER_X_OUT) ||
		!$stable(POINTER_Y_OUT) |-> $past(SYS_RST_IN) ||
		$past(WORD_VALID_IN && WORD_READY_OUT) ||
		$past(PIX_VALID_OUT && PIX_READY_IN))
		else $error("pointer changed without cause");
	step_adjacent_a: assert property (pix_taken ##1 PIX_VALID_OUT |->
		(PIX_X_OUT - $past(PIX_X_OUT) + 16'h0001) <= 16'h0002 &&
		(PIX_Y_OUT - $past(PIX_Y_OUT) + 16'h0001) <= 16'h0002)
		else $error("pixel step not to a neighbour");
	value_steady_a: assert property (PIX_VALID_OUT &&
		$past(PIX_VALID_OUT) |-> $stable(PIX_VALUE_OUT))
		else $error("pixel value changed within a line");
endmodule : rlpc_top_checker

// ---- testbench/rlpc_sink.sv ----
// Purpose: Pixel sink standing for the work-plane memory.
// Assumes: A pixel is taken at a rising edge with valid and ready high.
// Notes:   Slow mode grants one cycle in four to stretch handshakes.
`timescale 1ns/1ps
module rlpc_sink (
	// Clock
	input  wire logic clk_in,
	// Control
	input  wire logic slow_in,
	// Handshake
	output logic      ready_out
);
	logic [1:0] cnt_reg = 2'h0;
	always @(posedge clk_in) begin
		cnt_reg <= cnt_reg + 2'h1;
	end
	assign ready_out = !slow_in || cnt_reg == 2'h3;
endmodule : rlpc_sink

// ---- testbench/relative_line_and_pointer_cmds_test.sv ----
// Purpose: Self-checking bench for the relative line and pointer block.
// Assumes: 40 MHz clock, reset held for ten cycles.
// Notes:   Register commands run from a table, drawing by hand.
`timescale 1ns/1ps
module relative_line_and_pointer_cmds_test;
	logic        clk = 1'b0, rst = 1'b1, w_valid = 1'b0, slow = 1'b0;
	logic [15:0] w_data = 16'h0000;
	logic        w_ready, p_valid, p_ready, p_value, busy;
	logic        exp_value = 1'b0, first = 1'b1;
	logic [15:0] p_x, p_y, ptr_x, ptr_y, off_x, off_y;
	logic [15:0] first_x, first_y, last_x, last_y;
	int          bad_count = 0, samples_checked = 0;
	// Header, x, y, then expected pointer x, y and offset x, y.
	logic [15:0] rows [6][7] = '{
		'{16'h9000, 16'h0005, 16'h0007, 16'h0000, 16'h0000, 16'h0005, 16'h0007},
		'{16'h8000, 16'h0001, 16'h0002, 16'h0006, 16'h0009, 16'h0005, 16'h0007},
		'{16'h8800, 16'hFFFE, 16'hFFEC, 16'h0004, 16'hFFF5, 16'h0005, 16'h0007},
		'{16'h8000, 16'hFFFD, 16'h0000, 16'h0002, 16'h0007, 16'h0005, 16'h0007},
		'{16'h9000, 16'h0000, 16'h0000, 16'h0002, 16'h0007, 16'h0000, 16'h0000},
		'{16'h8000, 16'h0002, 16'h0003, 16'h0002, 16'h0003, 16'h0000, 16'h0000}};
	always #12.5 clk = ~clk;
	rlpc_top dut (.CLK_IN(clk), .SYS_RST_IN(rst), .WORD_VALID_IN(w_valid),
		.WORD_DATA_IN(w_data), .WORD_READY_OUT(w_ready),
		.PIX_VALID_OUT(p_valid), .PIX_READY_IN(p_ready), .PIX_X_OUT(p_x),
		.PIX_Y_OUT(p_y), .PIX_VALUE_OUT(p_value), .POINTER_X_OUT(ptr_x),
		.POINTER_Y_OUT(ptr_y), .OFFSET_X_OUT(off_x), .OFFSET_Y_OUT(off_y),
		.BUSY_OUT(busy));
	rlpc_sink sink (.clk_in(clk), .slow_in(slow), .ready_out(p_ready));
	task chk(input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task wrap_up;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// Sends words in order, then waits for the command to finish.
	task send(input logic [15:0] q[$]);
		int k;
		@(posedge clk);
		foreach (q[i]) begin
			w_valid <= 1'b1;
			w_data  <= q[i];
			do @(posedge clk); while (w_ready !== 1'b1);
		end
		w_valid <= 1'b0;
		for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk);
		#1;
	endtask : send
	always @(posedge clk) begin
		if (p_valid === 1'b1 && p_ready === 1'b1) begin
			if (first) begin
				first_x = p_x;
				first_y = p_y;
			end
			first  = 1'b0;
			last_x = p_x;
			last_y = p_y;
			chk({15'h0000, p_value}, {15'h0000, exp_value});
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		foreach (rows[r]) begin
			send('{rows[r][0], rows[r][1], rows[r][2]});
			chk(ptr_x, rows[r][3]);
			chk(ptr_y, rows[r][4]);
			chk(off_x, rows[r][5]);
			chk(off_y, rows[r][6]);
		end
		slow      = 1'b1;
		exp_value = 1'b1;
		send('{16'h5810, 16'h0002, 16'h0003, 16'h0001, 16'hFFFF, 16'h0002});
		chk(first_x, 16'h0002);
		chk(first_y, 16'h0003);
		chk(last_x, 16'h0004);
		chk(last_y, 16'h0006);
		chk(ptr_x, 16'h0004);
		chk(ptr_y, 16'h0006);
		slow      = 1'b0;
		exp_value = 1'b0;
		send('{16'h5800, 16'h0001, 16'hFFFF, 16'h0000});
		chk(last_x, 16'h0003);
		chk(ptr_x, 16'h0003);
		send('{16'h5800, 16'h0000, 16'h8800, 16'h0001, 16'h0001});
		chk(ptr_x, 16'h0004);
		chk(ptr_y, 16'h0007);
		send('{16'hF800, 16'h8000, 16'h0009, 16'h0008});
		chk(ptr_x, 16'h0009);
		chk(ptr_y, 16'h0008);
		send('{16'h9000, 16'h0003, 16'h0004});
		chk(off_y, 16'h0004);
		chk(ptr_x, 16'h0009);
		@(posedge clk);
		w_valid <= 1'b1;
		w_data  <= 16'h9000;
		@(posedge clk);
		rst     <= 1'b1;
		w_valid <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(ptr_x, 16'h0000);
		chk(off_y, 16'h0000);
		chk({15'h0000, busy}, 16'h0000);
		send('{16'h8000, 16'h0001, 16'h0001});
		chk(ptr_y, 16'h0001);
		chk(off_x, 16'h0000);
		wrap_up();
	end
endmodule : relative_line_and_pointer_cmds_test
bind rlpc_top rlpc_top_checker #(.W(W)) chk_i (.CLK_IN(CLK_IN),
	.SYS_RST_IN(SYS_RST_IN), .WORD_VALID_IN(WORD_VALID_IN),
	.WORD_DATA_IN(WORD_DATA_IN), .WORD_READY_OUT(WORD_READY_OUT),
	.PIX_VALID_OUT(PIX_VALID_OUT), .PIX_READY_IN(PIX_READY_IN),
	.PIX_X_OUT(PIX_X_OUT), .PIX_Y_OUT(PIX_Y_OUT),
	.PIX_VALUE_OUT(PIX_VALUE_OUT), .POINTER_X_OUT(POINTER_X_OUT),
	.POINTER_Y_OUT(POINTER_Y_OUT), .OFFSET_X_OUT(OFFSET_X_OUT),
	.OFFSET_Y_OUT(OFFSET_Y_OUT), .BUSY_OUT(BUSY_OUT));
